// *** core/pspap_pkg.sv ***
package pspap_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_LUT_INDEX_LOW = 8'h60;
  localparam logic [7:0] IDX_SPRITE_INDEX_HIGH = 8'h61;
  localparam logic [7:0] IDX_LUT_INDEX_LOW_WITH_FETCH = 8'h62;
  localparam logic [7:0] IDX_SPRITE_INDEX_HIGH_WITH_FETCH = 8'h63;
  localparam logic [7:0] IDX_PIXEL_LOOKUP_MASK = 8'h64;
  localparam logic [7:0] IDX_COLOUR_TABLE_DATA = 8'h65;
  localparam logic [7:0] IDX_COLOUR_ELEMENT_SEQUENCE = 8'h66;
  localparam logic [7:0] IDX_RED_FETCH_HOLD = 8'h67;
  localparam logic [7:0] IDX_GREEN_FETCH_HOLD = 8'h68;
  localparam logic [7:0] IDX_BLUE_FETCH_HOLD = 8'h69;
  localparam logic [7:0] IDX_CURSOR_IMAGE_DATA = 8'h6a;
  localparam logic [7:0] IDX_CURSOR_FETCH_HOLD = 8'h6b;
  // sequence register fields
  localparam int SEQ_ELEM_LSB = 0;
  localparam int SEQ_ORDER_BIT = 2;
  // element codes
  localparam logic [1:0] ELEM_RED = 2'h0;
  localparam logic [1:0] ELEM_GREEN = 2'h1;
  localparam logic [1:0] ELEM_BLUE = 2'h2;
  localparam logic [1:0] ELEM_DUMMY = 2'h3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [13:0] RST_INDEX = 14'h0000;
  localparam logic [7:0] RST_MASK = 8'hff;
  // sizes
  localparam int PAL_ENTRIES = 256;
  localparam int SPRITE_BYTES = 16384;
  // axi responses
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : pspap_pkg

// *** core/pspap_regs.sv ***
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// R01: palette uses 256 entries, low index byte
// R02: sprite index combines low and high bytes
// R03: plain index access has no side effect
// R04: interrupting tasks save, restore plain index
// R05: low fetch write loads rgb holds, increments
// R06: fetch write loads sprite hold, increments
// R07: palette reads use low fetch register only
// R08: task switches skip fetch index registers
// R09: pixel value ANDed with mask before lookup
// R10: palette data mirrors selected element
// R11: only upper six data bits are stored
// R12: mono display needs red, blue zeroed
// R13: element field selects r, g, b, dummy
// R14: order bit adds a dummy fourth element
// R15: rgb holds are read/write, saved by software
// R16: sprite data mirrors selected location
// R17: sprite pixels packed first pixel low bits
// R18: sprite hold is read/write holding register
// R19: element advances; wrap refetches, increments
module pspap_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // display side lookup path
  input wire logic [7:0] pixel_value,
  output logic [17:0] pixel_colour,
  input wire logic [13:0] cursor_addr,
  output logic [7:0] cursor_byte
);
  import pspap_pkg::*;

  // palette ram holds six-bit components per colour
  logic [5:0] pal_red [PAL_ENTRIES];
  logic [5:0] pal_green [PAL_ENTRIES];
  logic [5:0] pal_blue [PAL_ENTRIES];
  logic [7:0] sprite_mem [SPRITE_BYTES];

  // software-visible state
  logic [13:0] index_r; // combined sprite/palette index
  logic [7:0] mask_r;
  logic [1:0] elem_r; // current_element_field
  logic sequence_order_bit_r;
  logic [7:0] red_hold_r;
  logic [7:0] green_hold_r;
  logic [7:0] blue_hold_r;
  logic [7:0] cursor_hold_r;

  // write channel capture; address and data may come in either order
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic do_read;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic wmapped;
  logic rmapped;
  logic [7:0] wbyte;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // write commits the cycle both halves are held
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign widx = awaddr_r[9:2];
  assign ridx = s_axi_araddr[9:2];
  // only lane 0 carries the byte; other lanes are ignored
  assign wbyte = wdata_r[7:0];
  // address decode: aligned word, index within 60..6b
  assign wmapped = (awaddr_r[1:0] == 2'h0) &&
                   (awaddr_r[ADDR_W-1:10] == '0) &&
                   (widx >= IDX_LUT_INDEX_LOW) &&
                   (widx <= IDX_CURSOR_FETCH_HOLD);
  assign rmapped = (s_axi_araddr[1:0] == 2'h0) &&
                   (s_axi_araddr[ADDR_W-1:10] == '0) &&
                   (ridx >= IDX_LUT_INDEX_LOW) &&
                   (ridx <= IDX_CURSOR_FETCH_HOLD);

  // accesses that carry side effects
  logic wr_en;
  logic wr_fetch_lo;
  logic wr_fetch_hi;
  logic pal_wr;
  logic pal_rd;
  logic spr_wr;
  logic spr_rd;
  logic pal_access;
  logic spr_access;
  assign wr_en = do_write && wmapped && wstrb_r[0];
  assign wr_fetch_lo = wr_en && widx == IDX_LUT_INDEX_LOW_WITH_FETCH;
  assign wr_fetch_hi = wr_en &&
                       widx == IDX_SPRITE_INDEX_HIGH_WITH_FETCH;
  assign pal_wr = wr_en && widx == IDX_COLOUR_TABLE_DATA;
  assign pal_rd = do_read && rmapped && ridx == IDX_COLOUR_TABLE_DATA;
  assign spr_wr = wr_en && widx == IDX_CURSOR_IMAGE_DATA;
  assign spr_rd = do_read && rmapped && ridx == IDX_CURSOR_IMAGE_DATA;
  // a simultaneous read and write of the data port counts once
  assign pal_access = pal_wr || pal_rd;
  assign spr_access = spr_wr || spr_rd;

  // last element of an entry depends on the order bit
  logic elem_last;
  logic [1:0] elem_next;
  always_comb begin
    elem_last = sequence_order_bit_r ? (elem_r == ELEM_DUMMY)
                                     : (elem_r == ELEM_BLUE); // see R14
    elem_next = elem_last ? ELEM_RED : elem_r + 2'h1; // see R19
  end

  // index as written by the current access, before any increment
  logic [13:0] index_base;
  always_comb begin
    index_base = index_r;
    if (wr_en && (widx == IDX_LUT_INDEX_LOW ||
                  widx == IDX_LUT_INDEX_LOW_WITH_FETCH)) begin
      index_base = {index_r[13:8], wbyte};
    end else if (wr_en && (widx == IDX_SPRITE_INDEX_HIGH ||
                           widx == IDX_SPRITE_INDEX_HIGH_WITH_FETCH)) begin
      // only six bits exist above the low byte
      index_base = {wbyte[5:0], index_r[7:0]}; // see R02
    end
  end

  // palette entry that a prefetch loads from
  logic [7:0] fetch_entry;
  logic pal_fetch;
  logic pal_wrap;
  always_comb begin
    pal_wrap = pal_access && elem_last;
    pal_fetch = wr_fetch_lo || pal_wrap;
    // after a prefetch the index already names the following entry,
    // so a wrap refills from the index itself and then bumps it;
    // adding one here would skip every other entry on a burst read
    fetch_entry = wr_fetch_lo ? index_base[7:0]
                              : index_r[7:0]; // see R01 see R19
  end

  // index register: store, then increment on prefetch, wrap or sprite data access; a
  // wrapping palette or any sprite data access wins over a plain index write in the
  // same cycle, which only a read and a write landing together can cause
  always_ff @(posedge clock) begin
    if (rst) begin
      index_r <= RST_INDEX;
    end else if (wr_fetch_lo || wr_fetch_hi) begin
      index_r <= index_base + 14'h0001; // see R05 see R06
    end else if (pal_wrap || spr_access) begin
      index_r <= index_r + 14'h0001; // see R19
    end else begin
      index_r <= index_base; // plain index: store only, see R03
    end
  end

  // mask and sequence registers; the mask comes out of reset as all
  // ones so that pixels reach the whole colour table
  always_ff @(posedge clock) begin
    if (rst) begin
      mask_r <= RST_MASK;
      elem_r <= ELEM_RED;
      sequence_order_bit_r <= 1'b0;
    end else begin
      if (wr_en && widx == IDX_PIXEL_LOOKUP_MASK) begin
        mask_r <= wbyte;
      end
      if (wr_en && widx == IDX_COLOUR_ELEMENT_SEQUENCE) begin
        elem_r <= wbyte[SEQ_ELEM_LSB +: 2]; // see R13
        sequence_order_bit_r <= wbyte[SEQ_ORDER_BIT];
      end else if (wr_fetch_lo) begin
        elem_r <= ELEM_RED;
      end else if (pal_access) begin
        elem_r <= elem_next; // see R19
      end
    end
  end

  // palette ram writes go to the selected element only; the holding
  // registers are left alone except when the write wraps and refetches, so reading
  // the data port straight after a write shows the prefetched values, not the new ones
  always_ff @(posedge clock) begin
    if (pal_wr) begin
      case (elem_r) // see R13
        ELEM_RED: pal_red[index_r[7:0]] <= wbyte[7:2]; // see R11
        ELEM_GREEN: pal_green[index_r[7:0]] <= wbyte[7:2];
        ELEM_BLUE: pal_blue[index_r[7:0]] <= wbyte[7:2];
        default: ; // dummy element discards data
      endcase
    end
  end

  // colour holding registers; reads of data come from these
  always_ff @(posedge clock) begin
    if (rst) begin
      red_hold_r <= RST_BYTE;
      green_hold_r <= RST_BYTE;
      blue_hold_r <= RST_BYTE;
    end else if (pal_fetch) begin
      red_hold_r <= {pal_red[fetch_entry], 2'h0}; // see R05
      green_hold_r <= {pal_green[fetch_entry], 2'h0};
      blue_hold_r <= {pal_blue[fetch_entry], 2'h0};
    end else begin
      // software may restore them directly, see R15
      if (wr_en && widx == IDX_RED_FETCH_HOLD) red_hold_r <= wbyte;
      if (wr_en && widx == IDX_GREEN_FETCH_HOLD) green_hold_r <= wbyte;
      if (wr_en && widx == IDX_BLUE_FETCH_HOLD) blue_hold_r <= wbyte;
    end
  end

  // sprite buffer writes at the current index
  always_ff @(posedge clock) begin
    if (spr_wr) begin
      sprite_mem[index_r] <= wbyte; // packed as supplied, see R17
    end
  end

  // sprite hold refills from the next location after each access
  always_ff @(posedge clock) begin
    if (rst) begin
      cursor_hold_r <= RST_BYTE;
    end else if (wr_fetch_lo || wr_fetch_hi) begin
      cursor_hold_r <= sprite_mem[index_base]; // see R06
    end else if (spr_access) begin
      // the index runs one ahead of the shown byte, as after a
      // prefetch write, so consecutive reads walk the buffer in
      // order; the 14-bit index wraps from the top back to zero
      cursor_hold_r <= sprite_mem[index_r]; // see R16
    end else if (wr_en && widx == IDX_CURSOR_FETCH_HOLD) begin
      cursor_hold_r <= wbyte; // see R18
    end
  end

  // display lookup; one cycle of latency from flip-flops; the tables
  // are not reset, so a pixel shown before software loads the table
  // gives an unknown colour
  always_ff @(posedge clock) begin
    if (rst) begin
      pixel_colour <= 18'h00000;
      cursor_byte <= RST_BYTE;
    end else begin
      pixel_colour <= {pal_red[pixel_value & mask_r],
                       pal_green[pixel_value & mask_r],
                       pal_blue[pixel_value & mask_r]}; // see R09
      cursor_byte <= sprite_mem[cursor_addr];
    end
  end

  // read mux; selected element shown from holding registers
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    case (ridx)
      IDX_LUT_INDEX_LOW: rbyte = index_r[7:0]; // see R03
      IDX_SPRITE_INDEX_HIGH: rbyte = {2'h0, index_r[13:8]};
      IDX_LUT_INDEX_LOW_WITH_FETCH: rbyte = index_r[7:0];
      IDX_SPRITE_INDEX_HIGH_WITH_FETCH: rbyte = {2'h0, index_r[13:8]};
      IDX_PIXEL_LOOKUP_MASK: rbyte = mask_r;
      IDX_COLOUR_TABLE_DATA: begin
        case (elem_r) // see R10
          ELEM_RED: rbyte = red_hold_r;
          ELEM_GREEN: rbyte = green_hold_r;
          ELEM_BLUE: rbyte = blue_hold_r;
          default: rbyte = 8'h00;
        endcase
      end
      IDX_COLOUR_ELEMENT_SEQUENCE:
        rbyte = {5'h00, sequence_order_bit_r, elem_r};
      IDX_RED_FETCH_HOLD: rbyte = red_hold_r;
      IDX_GREEN_FETCH_HOLD: rbyte = green_hold_r;
      IDX_BLUE_FETCH_HOLD: rbyte = blue_hold_r;
      IDX_CURSOR_IMAGE_DATA: rbyte = cursor_hold_r; // see R16
      IDX_CURSOR_FETCH_HOLD: rbyte = cursor_hold_r;
      default: rbyte = 8'h00;
    endcase
  end

  // write address/data capture and response
  // a mapped write with byte lane 0 off answers okay but stores nothing
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wmapped ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read response one cycle after the address is taken
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= AXI_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rbyte};
      s_axi_rresp <= rmapped ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pspap_regs

// *** testbench/pspap_regs_sva.sv ***
`timescale 1ns/1ps
// watches the register port handshakes of the access port
module pspap_regs_sva (
  input logic clock,
  input logic rst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  import pspap_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_READ_ANSWER: assert property (s_axi_arvalid &&
    s_axi_arready && s_axi_rready |=> s_axi_rvalid ##1 !s_axi_rvalid)
    else $error("read answer not one cycle after address");
  AST_ARREADY_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  AST_RDATA_BYTE: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid &&
    s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1
    s_axi_bvalid)
    else $error("write response not two cycles after accept");
  AST_BVALID_DROP: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("write response held after taken");
  AST_WRITE_BLOCK: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_BRESP_CODE: assert property (s_axi_bvalid |->
    s_axi_bresp == AXI_OKAY || s_axi_bresp == AXI_SLVERR)
    else $error("write response code illegal");
  AST_RVALID_DROP: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid)
    else $error("read data held after taken");
endmodule : pspap_regs_sva

bind pspap_regs pspap_regs_sva u_sva (.clock, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);

// *** testbench/tb_palette_sprite_access_port.sv ***
`timescale 1ns/1ps
module tb_palette_sprite_access_port;
  import pspap_pkg::*;
  // register index, byte written, byte read back, response
  typedef struct packed {
    logic [7:0] i;
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] r;
  } pspap_row_s;
  logic clock, rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pixel_value, cursor_byte;
  logic [17:0] pixel_colour;
  logic [13:0] cursor_addr;
  int err_count, checks, cyc;
  // colours of entry 0x10, then of entry 0x11
  logic [7:0] pal [6] = '{8'hff, 8'h81, 8'h42, 8'h24, 8'h18, 8'h0c};
  logic [7:0] hv [4]; // expected holds, dummy last
  // 61 keeps bits 5:0, 66 keeps bits 2:0, 70 is unmapped
  pspap_row_s rows [9] = '{{8'h60, 8'hab, 8'hab, 2'h0},
    {8'h61, 8'hff, 8'h3f, 2'h0}, {8'h64, 8'h0f, 8'h0f, 2'h0},
    {8'h66, 8'hff, 8'h07, 2'h0}, {8'h67, 8'ha4, 8'ha4, 2'h0},
    {8'h68, 8'h3c, 8'h3c, 2'h0}, {8'h69, 8'hc0, 8'hc0, 2'h0},
    {8'h6b, 8'h77, 8'h77, 2'h0}, {8'h70, 8'h55, 8'h00, 2'h2}};

  pspap_regs #(.ADDR_W(12)) uut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pixel_value, .pixel_colour, .cursor_addr, .cursor_byte);

  // free running clock, 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [33:0] g, input logic [33:0] x);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  // address and data offered together, bready held until the answer
  task automatic wr(input logic [7:0] i, input logic [7:0] d,
    input logic [1:0] r = AXI_OKAY);
    @(posedge clock);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({s_axi_bresp, 32'h0}, {r, 32'h0});
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e,
    input logic [1:0] r = AXI_OKAY);
    @(posedge clock);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {r, 24'h0, e});
  endtask : rd

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    pixel_value = 8'h00;
    cursor_addr = 14'h0000;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(8'h64, 8'hff);
    rd(8'h60, 8'h00);
    for (int k = 0; k < 9; k++) begin
      wr(rows[k].i, rows[k].d, rows[k].r);
      rd(rows[k].i, rows[k].e, rows[k].r);
    end
    // high index byte stays 3f: palette must ignore it
    wr(8'h66, 8'h00);
    wr(8'h60, 8'h10);
    // entry 0x10 then entry 0x11, written as one stream
    for (int c = 0; c < 6; c++) wr(8'h65, pal[c]);
    for (int c = 0; c < 3; c++) hv[c] = pal[c] & 8'hfc;
    hv[3] = 8'h00;
    rd(8'h60, 8'h12);
    for (int e = 0; e < 4; e++) begin
      wr(8'h62, 8'h10);
      wr(8'h66, 8'h04 | 8'(e));
      rd(8'h65, hv[e]);
    end
    for (int o = 0; o < 2; o++) begin
      wr(8'h62, 8'h10);
      for (int c = 0; c < 3; c++) rd(8'h67 + 8'(c), hv[c]);
      wr(8'h66, 8'(o * 4));
      for (int c = 0; c < 3 + o; c++) rd(8'h65, hv[c]);
      rd(8'h60, 8'h12);
      rd(8'h66, 8'(o * 4));
    end
    // burst read across two entries with no new prefetch between
    wr(8'h66, 8'h00);
    wr(8'h62, 8'h10);
    for (int c = 0; c < 6; c++) rd(8'h65, pal[c] & 8'hfc);
    rd(8'h60, 8'h13);
    wr(8'h64, 8'h1f);
    pixel_value <= 8'hf0;
    repeat (2) @(posedge clock);
    chk(34'(pixel_colour), 34'({6'h3f, 6'h20, 6'h10}));
    // mono panel: red and blue of the entry programmed as zero
    wr(8'h66, 8'h00);
    wr(8'h60, 8'h20);
    wr(8'h65, 8'h00);
    wr(8'h65, 8'hb4);
    wr(8'h65, 8'h00);
    wr(8'h64, 8'h2f);
    pixel_value <= 8'h30;
    repeat (2) @(posedge clock);
    chk(34'(pixel_colour), 34'({6'h00, 6'h2d, 6'h00}));
    wr(8'h60, 8'hff);
    wr(8'h61, 8'h00);
    wr(8'h6a, 8'h5e);
    wr(8'h6a, 8'ha1);
    wr(8'h60, 8'hff);
    wr(8'h63, 8'h00);
    rd(8'h6b, 8'h5e);
    rd(8'h61, 8'h01);
    rd(8'h60, 8'h00);
    // interrupting task: palette use through the low fetch index,
    // then the plain index and sprite hold put back by hand
    wr(8'h62, 8'h10);
    rd(8'h65, 8'hfc);
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h01);
    wr(8'h6b, 8'h5e);
    rd(8'h6a, 8'h5e);
    rd(8'h6a, 8'ha1);
    rd(8'h60, 8'h02);
    cursor_addr <= 14'h00ff;
    repeat (2) @(posedge clock);
    chk(34'(cursor_byte), 34'h5e);
    // second reset in mid-run brings every register back
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(8'h64, RST_MASK);
    rd(8'h66, RST_BYTE);
    rd(8'h67, RST_BYTE);
    rd(8'h6b, RST_BYTE);
    rd(8'h61, RST_BYTE);
    print_verdict();
  end
endmodule : tb_palette_sprite_access_port
